// File: verilog/sbf_pkg.sv
// Purpose: Shared constants and types for the bit-rate and format block
// Assumes: 32-bit Avalon-MM register window, byte addresses
// Notes:   Offsets, field positions, register reset values and post-divider and receiver counts live here
package sbf_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [4:0] OFF_DIVISOR  = 5'h00; // bit_rate_divisor
  localparam logic [4:0] OFF_MODE     = 5'h04; // serial_mode_reg
  localparam logic [4:0] OFF_WAITCTL  = 5'h08; // wait_state_ctrl_reg
  localparam logic [4:0] OFF_IFMODE   = 5'h0c; // serial_interface_mode
  localparam logic [4:0] OFF_TXHOLD   = 5'h10; // transmit_holding_reg
  localparam logic [4:0] OFF_RXHOLD   = 5'h14; // receive_holding_reg
  localparam logic [4:0] OFF_STATUS   = 5'h18; // receive status

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int MODE_SYNC_BIT   = 7; // Clocked synchronous select
  localparam int MODE_PSEL_HI    = 1; // prescale_select_hi
  localparam int MODE_PSEL_LO    = 0; // prescale_select_lo
  localparam int WAIT_DOUBLE_BIT = 0; // prescale_double
  localparam int IF_ORDER_BIT    = 3; // bit_order_select
  localparam int IF_INVERT_BIT   = 2; // data_invert
  localparam int IF_SELECT_BIT   = 0; // interface_mode_select
  localparam int STAT_FULL_BIT   = 0; // Receive holding full
  localparam int STAT_FRAME_BIT  = 1; // Stop bit was low
  localparam int STAT_BUSY_BIT   = 2; // Receiver inside a frame

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] DIVISOR_RESET = 8'hff;
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] IFMODE_RESET  = 8'hf2;
  localparam logic [7:0] IFMODE_ONES   = 8'hf2; // Bits that read as one

  // ---------------------------------------------------------------------
  // Timing counts, in generator ticks, sample ticks and data bits
  // ---------------------------------------------------------------------
  localparam logic [4:0] ASYNC_POST_LAST = 5'd31; // 32 ticks per bit
  localparam logic [4:0] SYNC_POST_LAST  = 5'd3;  // 4 ticks per bit
  localparam logic [4:0] SYNC_CLK_HALF   = 5'd1;  // Mid-bit clock edge
  localparam logic [3:0] OVERSAMPLE_LAST = 4'd15; // 16 samples per bit
  localparam logic [3:0] SAMPLE_POINT    = 4'd7;  // 8th sample
  localparam logic [2:0] DATA_BITS_LAST  = 3'd7;  // 8 data bits

  // ---------------------------------------------------------------------
  // Receiver states
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_t;

  // Bit order and inversion between holding register and line
  function automatic logic [7:0] fmt_byte(input logic [7:0] din,
                                          input logic       msb_first,
                                          input logic       invert);
    logic [7:0] r;
    r = din;
    if (msb_first) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = din[7-i];
      end
    end
    fmt_byte = invert ? ~r : r;
  endfunction : fmt_byte

endpackage : sbf_pkg

// File: verilog/sbf_prescaler.sv
// Purpose: Generator input clock selection and prescaling
// Assumes: periph_tick marks one peripheral clock period on ref_clk
// Notes:   n of zero passes the system clock straight through
`timescale 1ns/1ns
module sbf_prescaler
  import sbf_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Selection
  input  wire logic       periph_tick,
  input  wire logic [1:0] sel,
  input  wire logic       dbl,
  // Output enable pulse
  output logic            gen_tick_q
);

  typedef struct packed {
    logic [6:0] cnt;  // Peripheral clock count
    logic       tick; // Registered output
  } pre_t;

  pre_t s_q;
  pre_t s_d;
  logic [6:0] mask; // Ratio minus one

  // ---------------------------------------------------------------------
  // Ratio: 4, 16, 64, or twice that when doubled
  // ---------------------------------------------------------------------
  always_comb begin
    s_d  = s_q;
    case (sel)
      2'd1:    mask = dbl ? 7'h07 : 7'h03;
      2'd2:    mask = dbl ? 7'h1f : 7'h0f;
      2'd3:    mask = dbl ? 7'h7f : 7'h3f;
      default: mask = 7'h00;
    endcase
    if (sel == 2'd0) begin
      // System clock used directly
      s_d.tick = 1'b1;
    end else begin
      // Peripheral clock prescaled
      s_d.tick = periph_tick && ((s_q.cnt & mask) == mask);
    end
    if (periph_tick) begin
      s_d.cnt = s_q.cnt + 7'd1;
    end
  end

  // Single register stage
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign gen_tick_q = s_q.tick;

endmodule : sbf_prescaler

// File: verilog/sbf_divisor.sv
// Purpose: Reloading divisor counter of the bit-rate generator
// Assumes: tick_in is a one-cycle enable from the prescaler
// Notes:   A new divisor is taken at the next reload only
`timescale 1ns/1ns
module sbf_divisor
  import sbf_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Input ticks and divisor
  input  wire logic       tick_in,
  input  wire logic [7:0] divisor,
  // One tick per divisor plus one inputs
  output logic            tick_q
);

  typedef struct packed {
    logic [7:0] cnt;  // Remaining inputs
    logic       tick; // Registered output
  } div_t;

  div_t s_q;
  div_t s_d;

  // ---------------------------------------------------------------------
  // Count down, reload from divisor at zero
  // ---------------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (tick_in) begin
      if (s_q.cnt == 8'h00) begin
        s_d.cnt  = divisor;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 8'h01;
      end
    end
  end

  // Single register stage
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_q = s_q.tick;

endmodule : sbf_divisor

// File: verilog/sbf_core.sv
// Purpose: Bit-rate generation and data format control, Avalon-MM slave
// Assumes: All inputs synchronous to ref_clk; rx_line idles high
// Notes:   Async receiver built in; transmit word is given preformatted
//
// Behaviour
// - Async bit rate is source over 64*2^(2n-1)*(N+1)
// - Sync bit rate is source over 8*2^(2n-1)*(N+1)
// - Divisor is eight bits, any value 0..255
// - Prescale picks clock /4 /16 /64, doubled optionally
// - Interface mode loads f2 on reset, standby
// - Interface mode bits 7..4 fixed, read one
// - Interface mode bit 1 fixed, reads one
// - Bit order select: zero LSB first, one MSB
// - Invert bit flips data bits both directions
// - Receiver syncs on start edge, samples eighth
// - Sync select chooses framing and rate relation
`timescale 1ns/1ns
module sbf_core
  import sbf_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // System side
  input  wire logic        standby,
  input  wire logic        periph_tick,
  // Serial line side
  input  wire logic        rx_line,
  output logic [7:0]       tx_word_q,
  output logic             bit_tick_q,
  output logic             sample_tick_q,
  output logic             serial_clk_q,
  output logic             rx_valid_q
);

  // ---------------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  divisor;     // bit_rate_divisor
    logic [7:0]  mode;        // serial_mode_reg
    logic        dbl;         // prescale_double
    logic        order;       // bit_order_select
    logic        invert;      // data_invert
    logic        if_sel;      // interface_mode_select
    logic [7:0]  txh;         // transmit_holding_reg, raw
    logic [7:0]  rxh;         // receive_holding_reg, formatted
    logic        rx_full;     // Sticky, cleared by read
    logic        frame_err;   // Sticky, cleared by writing one
    logic [31:0] rdata;       // Read answer
    logic        wait_r;      // waitrequest
    logic [4:0]  post;        // Generator tick count within a bit
    logic        bit_tick;    // One pulse per bit period
    logic        sample_tick; // 16 times bit rate in async mode
    logic        sclk;        // Sync serial clock
    rx_state_t   rx_st;       // Receiver state
    logic [3:0]  os_cnt;      // Oversample count
    logic [2:0]  bit_cnt;     // Data bit count
    logic [7:0]  shreg;       // First bit lands in bit 0
    logic        rx_prev;     // Line one cycle ago
    logic        rx_valid;    // Byte stored pulse
    logic [7:0]  tx_word;     // Formatted transmit word
  } core_t;

  core_t s_q;
  core_t s_d;

  logic       pre_tick;  // Generator input clock enable
  logic       gen_tick;  // Divided tick, every N+1 inputs
  logic       sync_mode; // Clocked synchronous selected
  logic       access;    // Bus access accepted this cycle
  logic [7:0] if_read;   // Interface mode read value
  logic [7:0] rx_byte;   // Formatted receive byte

  assign sync_mode = s_q.mode[MODE_SYNC_BIT];

  // ---------------------------------------------------------------------
  // Bit-rate generator chain
  // ---------------------------------------------------------------------
  sbf_prescaler u_pre (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .periph_tick (periph_tick),
    .sel         ({s_q.mode[MODE_PSEL_HI], s_q.mode[MODE_PSEL_LO]}),
    .dbl         (s_q.dbl),
    .gen_tick_q  (pre_tick)
  );

  sbf_divisor u_div (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .tick_in (pre_tick),
    .divisor (s_q.divisor),
    .tick_q  (gen_tick)
  );

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    s_d             = s_q;
    s_d.bit_tick    = 1'b0;
    s_d.sample_tick = 1'b0;
    s_d.rx_valid    = 1'b0;
    s_d.rx_prev     = rx_line;
    access          = (read || write) && !s_q.wait_r;
    rx_byte         = fmt_byte(s_q.shreg, s_q.order, s_q.invert);

    // Fixed bits always read as one
    if_read = IFMODE_ONES;
    if_read[IF_ORDER_BIT]  = s_q.order;
    if_read[IF_INVERT_BIT] = s_q.invert;
    if_read[IF_SELECT_BIT] = s_q.if_sel;

    // Post divider: 32 ticks per bit async, 4 per bit sync
    if (gen_tick) begin
      if (sync_mode) begin
        // Clock toggles mid-bit and at bit end
        if (s_q.post >= SYNC_POST_LAST) begin
          s_d.post     = 5'd0;
          s_d.bit_tick = 1'b1;
          s_d.sclk     = 1'b1;
        end else begin
          s_d.post = s_q.post + 5'd1;
          if (s_q.post == SYNC_CLK_HALF) begin
            s_d.sclk = 1'b0;
          end
        end
      end else begin
        s_d.sclk = 1'b1;
        // Every second tick is one 16x sample clock
        s_d.sample_tick = s_q.post[0];
        if (s_q.post == ASYNC_POST_LAST) begin
          s_d.post     = 5'd0;
          s_d.bit_tick = 1'b1;
        end else begin
          s_d.post = s_q.post + 5'd1;
        end
      end
    end

    // Async receiver on the 16x sample clock
    case (s_q.rx_st)
      RX_IDLE: begin
        // Falling edge of the start bit restarts the count
        if (!sync_mode && s_q.rx_prev && !rx_line) begin
          s_d.rx_st  = RX_START;
          s_d.os_cnt = 4'd0;
        end
      end
      RX_START: begin
        if (s_d.sample_tick) begin
          s_d.os_cnt = s_q.os_cnt + 4'd1;
          if (s_q.os_cnt == SAMPLE_POINT) begin
            // Glitch shorter than half a bit is dropped
            s_d.rx_st   = rx_line ? RX_IDLE : RX_DATA;
            s_d.os_cnt  = 4'd0;
            s_d.bit_cnt = 3'd0;
          end
        end
      end
      RX_DATA: begin
        if (s_d.sample_tick) begin
          s_d.os_cnt = s_q.os_cnt + 4'd1;
          if (s_q.os_cnt == OVERSAMPLE_LAST) begin
            // Bit centre, 16 samples after the last one
            s_d.shreg   = {rx_line, s_q.shreg[7:1]};
            s_d.bit_cnt = s_q.bit_cnt + 3'd1;
            if (s_q.bit_cnt == DATA_BITS_LAST) begin
              s_d.rx_st = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (s_d.sample_tick) begin
          s_d.os_cnt = s_q.os_cnt + 4'd1;
          if (s_q.os_cnt == OVERSAMPLE_LAST) begin
            s_d.rx_st    = RX_IDLE;
            s_d.rxh      = rx_byte;
            s_d.rx_valid = 1'b1;
            if (!rx_line) begin
              s_d.frame_err = 1'b1;
            end
          end
        end
      end
      default: begin
        s_d.rx_st = RX_IDLE;
      end
    endcase
    // Switching to sync mode abandons a frame
    if (sync_mode) begin
      s_d.rx_st = RX_IDLE;
    end

    // Bus answer: waitrequest drops one cycle after the request
    s_d.wait_r = !((read || write) && s_q.wait_r);
    if ((read || write) && s_q.wait_r) begin
      case (address)
        OFF_DIVISOR: s_d.rdata = {24'h0, s_q.divisor};
        OFF_MODE:    s_d.rdata = {24'h0, s_q.mode};
        OFF_WAITCTL: s_d.rdata = {31'h0, s_q.dbl};
        OFF_IFMODE:  s_d.rdata = {24'h0, if_read};
        OFF_TXHOLD:  s_d.rdata = {24'h0, s_q.txh};
        OFF_RXHOLD:  s_d.rdata = {24'h0, s_q.rxh};
        OFF_STATUS:  s_d.rdata = {29'h0, (s_q.rx_st != RX_IDLE),
                                  s_q.frame_err, s_q.rx_full};
        default:     s_d.rdata = 32'h0;
      endcase
    end

    // Register writes and read side effects
    if (access && write && byteenable[0]) begin
      case (address)
        OFF_DIVISOR: s_d.divisor = writedata[7:0];
        OFF_MODE:    s_d.mode    = writedata[7:0];
        OFF_WAITCTL: s_d.dbl     = writedata[WAIT_DOUBLE_BIT];
        OFF_IFMODE: begin
          // Only the three writable bits are kept
          s_d.order  = writedata[IF_ORDER_BIT];
          s_d.invert = writedata[IF_INVERT_BIT];
          s_d.if_sel = writedata[IF_SELECT_BIT];
        end
        OFF_TXHOLD:  s_d.txh = writedata[7:0];
        OFF_STATUS: begin
          if (writedata[STAT_FRAME_BIT] && !(s_d.frame_err && !s_q.frame_err))
          begin
            s_d.frame_err = 1'b0;
          end
        end
        default: begin
          // Unmapped write ignored
        end
      endcase
    end
    if (access && read && (address == OFF_RXHOLD)) begin
      s_d.rx_full = 1'b0;
    end
    // A byte arriving with the clearing read is kept
    if (s_d.rx_valid) begin
      s_d.rx_full = 1'b1;
    end

    // Standby reloads the interface mode
    if (standby) begin
      s_d.order  = IFMODE_RESET[IF_ORDER_BIT];
      s_d.invert = IFMODE_RESET[IF_INVERT_BIT];
      s_d.if_sel = IFMODE_RESET[IF_SELECT_BIT];
    end

    // Transmit word leaves LSB first on the line
    s_d.tx_word = fmt_byte(s_d.txh, s_d.order, s_d.invert);
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q         <= '0;
      s_q.divisor <= DIVISOR_RESET;
      s_q.mode    <= MODE_RESET;
      s_q.order   <= IFMODE_RESET[IF_ORDER_BIT];
      s_q.invert  <= IFMODE_RESET[IF_INVERT_BIT];
      s_q.if_sel  <= IFMODE_RESET[IF_SELECT_BIT];
      s_q.wait_r  <= 1'b1;
      s_q.sclk    <= 1'b1;
      s_q.rx_st   <= RX_IDLE;
      s_q.rx_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs, all from the state register
  // ---------------------------------------------------------------------
  assign readdata      = s_q.rdata;
  assign waitrequest   = s_q.wait_r;
  assign tx_word_q     = s_q.tx_word;
  assign bit_tick_q    = s_q.bit_tick;
  assign sample_tick_q = s_q.sample_tick;
  assign serial_clk_q  = s_q.sclk;
  assign rx_valid_q    = s_q.rx_valid;

endmodule : sbf_core

// File: bench/sbf_core_monitor.sv
// Purpose: Port-level assertions for the bit-rate and format block
// Assumes: Bound to sbf_core, one clock domain
// Notes:   Watches bus inputs, standby and design outputs
`timescale 1ns/1ns
module sbf_core_monitor
  import sbf_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // Register bus
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // System and line side
  input wire logic        standby,
  input wire logic        bit_tick_q,
  input wire logic        sample_tick_q,
  input wire logic        serial_clk_q,
  input wire logic        rx_valid_q
);
  // --------------------
  // Clocking and steps
  // --------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Answered read of the interface mode register
  sequence ifmode_ack_s;
    read && !waitrequest && (address == OFF_IFMODE);
  endsequence

  // Standby held long enough to reload the register
  sequence standby_held_s;
    standby [*4];
  endsequence

  // --------------------
  // Assertions
  // --------------------
  ack_one_cycle_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  answer_next_a: assert property
    (($rose(read) || $rose(write)) && waitrequest |=> !waitrequest)
    else $error("bus request not answered after one cycle");
  fixed_ones_a: assert property
    (ifmode_ack_s |-> readdata[7:4] == 4'hf)
    else $error("interface mode upper bits not one");
  bit_one_a: assert property (ifmode_ack_s |-> readdata[1])
    else $error("interface mode bit one not set");
  standby_load_a: assert property
    (standby_held_s ##0 ifmode_ack_s |-> readdata[7:0] == IFMODE_RESET)
    else $error("interface mode not reloaded in standby");
  upper_zero_a: assert property
    (read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  sample_async_a: assert property (sample_tick_q |-> serial_clk_q)
    else $error("sample tick outside async mode");
  sample_gap_a: assert property (sample_tick_q |=> !sample_tick_q)
    else $error("sample tick wider than one cycle");
  bit_pulse_a: assert property (bit_tick_q |=> !bit_tick_q)
    else $error("bit tick wider than one cycle");
  bit_clock_a: assert property (bit_tick_q |-> serial_clk_q)
    else $error("serial clock low at bit tick");
  rx_pulse_a: assert property (rx_valid_q |=> !rx_valid_q)
    else $error("receive valid wider than one cycle");
endmodule : sbf_core_monitor

bind sbf_core sbf_core_monitor mon (
  .ref_clk(ref_clk), .rstn(rstn), .address(address), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .standby(standby), .bit_tick_q(bit_tick_q),
  .sample_tick_q(sample_tick_q), .serial_clk_q(serial_clk_q),
  .rx_valid_q(rx_valid_q)
);

// File: bench/remote_link.sv
// Purpose: Remote serial device sending async frames
// Assumes: Bit length given in ref_clk cycles
// Notes:   Line idles high, the mark state, between frames
`timescale 1ns/1ns
module remote_link
(
  // Clock
  input wire logic ref_clk,
  // Line towards the block
  output logic     line_q
);
  initial line_q = 1'b1;

  // Start bit, eight data bits LSB first, one stop bit
  task automatic send(input logic [7:0] b, input int cyc);
    logic [9:0] frame;
    // No parity bit, so inversion never has one to leave alone
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_q <= frame[i];
      repeat (cyc) @(posedge ref_clk);
    end
  endtask : send
endmodule : remote_link

// File: bench/serial_bitrate_and_format_ctrl_tb_top.sv
// Purpose: Self-checking bench for the bit-rate and format block
// Assumes: periph_tick high, or every other cycle for a halved clock
// Notes:   Bit periods measured in ref_clk cycles between bit ticks
`timescale 1ns/1ns
module serial_bitrate_and_format_ctrl_tb_top
  import sbf_pkg::*;
;
  // --------------------
  // Signals and instances
  // --------------------
  logic        ref_clk, rstn, read, write, standby, periph_tick;
  logic [4:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic [7:0]  tx_word_q;
  logic        waitrequest, bit_tick_q, sample_tick_q;
  logic        serial_clk_q, rx_valid_q;
  wire logic   rx_line;
  int          fail_count, n_checks;
  bit          ph_half; // Peripheral clock at half the system rate

  sbf_core dut (.ref_clk(ref_clk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .standby(standby),
    .periph_tick(periph_tick), .rx_line(rx_line), .tx_word_q(tx_word_q),
    .bit_tick_q(bit_tick_q), .sample_tick_q(sample_tick_q),
    .serial_clk_q(serial_clk_q), .rx_valid_q(rx_valid_q));
  remote_link partner (.ref_clk(ref_clk), .line_q(rx_line));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Peripheral clock: every cycle, or every second cycle when halved
  always @(posedge ref_clk) begin
    periph_tick <= ph_half ? ~periph_tick : 1'b1;
  end

  // --------------------
  // Shared tasks
  // --------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int k;
    @(posedge ref_clk);
    address    <= a;
    writedata  <= {24'h0, d};
    byteenable <= be;
    read       <= ~wr;
    write      <= wr;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (k >= 50) check("bus answer", 32'h0, 32'h1);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h0, 4'h0, q);
    check("read data", {24'h0, exp}, q);
  endtask : rd

  // Edges up to and including the next bit tick, and clock-low cycles
  task automatic wait_tick(output int gap, output int low);
    gap = 0;
    low = 0;
    do begin
      @(posedge ref_clk);
      gap++;
      if (serial_clk_q === 1'b0) low++;
    end while (bit_tick_q !== 1'b1 && gap < 10000);
  endtask : wait_tick

  // Independent model of bit order and inversion
  function automatic logic [7:0] fmt(logic [7:0] b, logic o, logic v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = o ? b[7-i] : b[i];
    return v ? ~r : r;
  endfunction : fmt

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset();
    rd(OFF_IFMODE, 8'hf2);
    rd(OFF_DIVISOR, 8'hff);
    rd(5'h1c, 8'h00);
  endtask : t_reset

  task automatic t_ifmode();
    logic [31:0] q;
    wr(OFF_IFMODE, 8'h0c);
    rd(OFF_IFMODE, 8'hfe);
    wr(OFF_IFMODE, 8'h00);
    rd(OFF_IFMODE, 8'hf2);
    wr(OFF_IFMODE, 8'h0c);
    standby <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(OFF_IFMODE, 8'hf2);
    standby <= 1'b0;
    rd(OFF_IFMODE, 8'hf2);
    // Write without the low byte lane must be ignored
    bus(1'b1, OFF_DIVISOR, 8'h12, 4'h0, q);
    rd(OFF_DIVISOR, 8'hff);
  endtask : t_ifmode

  // Config is {half rate, sync, double, n, divisor}
  // 0800 is the fastest sync rate: tick spacing and clock-low count are both judged there
  task automatic t_rate();
    logic [12:0] cfg [10] = '{13'h0003, 13'h0000, 13'h0800, 13'h08ff,
                              13'h0100, 13'h0601, 13'h0300, 13'h0f00,
                              13'h1000, 13'h1100};
    int g, lo, ex, nn;
    for (int i = 0; i < 10; i++) begin
      nn = int'(cfg[i][9:8]);
      ex = (cfg[i][11] ? 4 : 32) * (int'(cfg[i][7:0]) + 1);
      if (nn != 0) ex = ex * (4 ** nn) * (cfg[i][10] ? 2 : 1);
      // Halved peripheral clock only slows n above zero
      if (nn != 0 && cfg[i][12]) ex = ex * 2;
      ph_half <= cfg[i][12];
      wr(OFF_DIVISOR, cfg[i][7:0]);
      rd(OFF_DIVISOR, cfg[i][7:0]);
      wr(OFF_MODE, {cfg[i][11], 5'h0, cfg[i][9:8]});
      wr(OFF_WAITCTL, {7'h0, cfg[i][10]});
      wait_tick(g, lo);
      wait_tick(g, lo);
      wait_tick(g, lo);
      check("bit period", ex, g);
      check("serial clock low", cfg[i][11] ? ex / 2 : 0, lo);
    end
    ph_half <= 1'b0;
  endtask : t_rate

  // Transmit and receive format for every order and invert setting
  task automatic t_format();
    logic [7:0] e;
    int k;
    wr(OFF_MODE, 8'h00);
    wr(OFF_DIVISOR, 8'h00);
    wr(OFF_WAITCTL, 8'h00);
    for (int m = 0; m < 4; m++) begin
      e = fmt(8'h4b, m[1], m[0]);
      wr(OFF_IFMODE, {4'h0, m[1], m[0], 2'b00});
      wr(OFF_TXHOLD, 8'h4b);
      repeat (2) @(posedge ref_clk);
      check("tx word", {24'h0, e}, {24'h0, tx_word_q});
      k = 0;
      fork
        partner.send(8'h4b, 32);
        while (rx_valid_q !== 1'b1 && k < 1000) begin
          @(posedge ref_clk);
          k++;
        end
      join
      check("rx valid seen", 32'h1, {31'h0, k < 1000});
      rd(OFF_STATUS, 8'h01);
      rd(OFF_RXHOLD, e);
    end
    // Reading the holding register empties it
    rd(OFF_STATUS, 8'h00);
  endtask : t_format

  // --------------------
  // Run control
  // --------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'h0;
    standby = 1'b0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_ifmode();
    t_rate();
    t_format();
    conclude();
  end

  // Watchdog well above the longest expected run
  initial begin
    repeat (80000) @(posedge ref_clk);
    fail_count++;
    conclude();
  end
endmodule : serial_bitrate_and_format_ctrl_tb_top
